// >>> logic/tmcu_top.sv
// Timer match compare unit: capture, compare, special event trigger, Avalon-MM registers
//
// Behaviour
// RULE1: In compare modes, compare value pair continuously against shared 16-bit timer count.
// RULE2: On match apply mode action: toggle, set, clear pin, special event, or interrupt only.
// RULE3: Every compare match sets the interrupt flag in the same edge as the action.
// RULE4: Mode 1010 leaves the pin undriven and only raises the interrupt flag.
// RULE5: Mode 1011 match resets timer and starts conversion if converter enabled; pin undriven.
// RULE6: Trigger pulses at the match; timer clear waits for next timer clock rise.
// RULE7: Timer clear by the trigger never sets the timer overflow flag.
// RULE8: If the value no longer matches at that timer clock rise, skip the timer clear.
// RULE9: Writing zero to the control register forces the compare output latch low.
// RULE10: Software clears the pin direction bit before relying on compare outputs.
// RULE11: Shared timer runs in timer or synchronized counter mode, not asynchronous.
// RULE12: Shared timer is clocked by instruction clock or external clock, not system clock.
// RULE13: Compare need not work in sleep; it is gated off there.
// RULE14: With instruction clock source the timer holds its count through sleep.
// RULE15: Capture keeps working in sleep with an external timer clock source.
// RULE16: Selected pin event copies the timer count into the value pair.
// RULE17: Each capture sets the flag, cleared only by software; new capture overwrites.
// RULE18: Prescaler counter clears when off, not capturing, or reset; not on select change.
// RULE19: Software writes zero before a new prescaler and mode, in one write.
// RULE20: Toggle, set and clear use the unit's own mode encodings.
// RULE21: Trigger is a one-cycle pulse to timer reset and converter start, gated by enable.
`timescale 1ns/1ps
`default_nettype none
module tmcu_top
  import tmcu_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] timer_count,
  input wire logic timer_clk_rise,
  input wire logic timer_ext_clk,
  input wire logic adc_enable,
  input wire logic sleep_active,
  input wire logic module_pin_in,
  output logic module_pin_out,
  output logic module_pin_oe_n,
  output logic special_event,
  output logic timer_clear,
  output logic adc_start,
  output logic timer_hold,
  output logic module_interrupt_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  tmcu_control_t control_r;
  logic [15:0] value_r;
  logic flag_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic cmp_latch_r;
  logic oe_n_r;
  logic match_prev_r;
  logic pend_r;
  logic sev_r;
  logic tclr_r;
  logic adc_r;
  logic hold_r;
  logic [3:0] mode;
  logic compare_on;
  logic capture_on;
  logic equal_now;
  logic match_live;
  logic match_hit;
  logic special_mode;
  logic cap_event;
  logic pin_level;
  logic rd_take;
  logic wr_fire;
  logic wr_low;
  logic flag_clear;
  logic [31:0] rdata_nxt;

  assign mode = control_r.operating_mode_field;
  assign compare_on = tmcu_is_compare(mode);
  assign capture_on = tmcu_is_capture(mode);
  assign special_mode = (mode == TMCU_MODE_SPECIAL);

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave handshake
  // One wait cycle per access keeps read data registered and the timing fixed
  assign rd_take = avs_read & wait_r & ~avs_write;
  assign wr_fire = avs_write & ~wait_r & ~avs_read;
  assign wr_low = wr_fire & avs_byteenable[0];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 1'b1;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if (avs_read ^ avs_write) begin
      wait_r <= 1'b0;
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (avs_address)
      TMCU_OFS_CONTROL: rdata_nxt[TMCU_REG_W-1:0] = control_r;
      TMCU_OFS_VALUE_LOW: rdata_nxt[TMCU_REG_W-1:0] = value_r[TMCU_REG_W-1:0];
      TMCU_OFS_VALUE_HIGH: rdata_nxt[TMCU_REG_W-1:0] = value_r[TMCU_CNT_W-1:TMCU_REG_W];
      TMCU_OFS_STATUS: begin
        rdata_nxt[TMCU_STAT_FLAG] = flag_r;
        rdata_nxt[TMCU_STAT_PEND] = pend_r;
        rdata_nxt[TMCU_STAT_PIN] = pin_level;
      end
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      control_r <= TMCU_CONTROL_RST;
    end else if (wr_low && (avs_address == TMCU_OFS_CONTROL)) begin
      control_r <= avs_writedata[TMCU_REG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture pin path
  tmcu_capture_edge u_capture (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin_async(module_pin_in),
    .capture_on(capture_on),
    .prescale_sel(mode[1:0]),
    .pin_level(pin_level),
    .capture_event(cap_event)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Value register pair
  // RULE16: timer count captured
  // RULE15: capture not gated by sleep
  // RULE17: newer capture overwrites
  // A capture in the same cycle as a software write wins, so no event is lost
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      value_r <= TMCU_VALUE_RST;
    end else if (cap_event) begin
      value_r <= timer_count;
    end else if (wr_low && (avs_address == TMCU_OFS_VALUE_LOW)) begin
      value_r[TMCU_REG_W-1:0] <= avs_writedata[TMCU_REG_W-1:0];
    end else if (wr_low && (avs_address == TMCU_OFS_VALUE_HIGH)) begin
      value_r[TMCU_CNT_W-1:TMCU_REG_W] <= avs_writedata[TMCU_REG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare detection
  // RULE1: continuous equality check
  assign equal_now = (timer_count == value_r);
  // RULE13: compare gated in sleep
  assign match_live = compare_on & ~sleep_active & equal_now;
  // One action per arrival at the value, not one per system clock while it holds
  assign match_hit = match_live & ~match_prev_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      match_prev_r <= 1'b0;
    end else begin
      match_prev_r <= match_live;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare output latch and pin drive
  // RULE2: match action select
  // RULE20: own mode encodings
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmp_latch_r <= 1'b0;
    end else if (wr_low && (avs_address == TMCU_OFS_CONTROL) &&
                 (avs_writedata[TMCU_REG_W-1:0] == TMCU_CONTROL_OFF)) begin
      // RULE9: zero write clears latch
      cmp_latch_r <= 1'b0;
    end else if (match_hit) begin
      unique case (mode)
        TMCU_MODE_TOGGLE: cmp_latch_r <= ~cmp_latch_r;
        TMCU_MODE_SET: cmp_latch_r <= 1'b1;
        TMCU_MODE_CLEAR: cmp_latch_r <= 1'b0;
        default: cmp_latch_r <= cmp_latch_r;
      endcase
    end
  end

  // RULE4: interrupt mode pin free
  // RULE5: trigger mode pin free
  // RULE10: direction bit kept outside
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= ~tmcu_drives_pin(mode);
    end
  end

  assign module_pin_out = cmp_latch_r;
  assign module_pin_oe_n = oe_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flag
  // RULE3: flag with match action
  // RULE17: software clear only
  // Set wins over a write-one clear in the same cycle
  assign flag_clear = wr_low && (avs_address == TMCU_OFS_STATUS) && avs_writedata[TMCU_STAT_FLAG];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= 1'b0;
    end else if (match_hit || cap_event) begin
      flag_r <= 1'b1;
    end else if (flag_clear) begin
      flag_r <= 1'b0;
    end
  end

  assign module_interrupt_flag = flag_r;

  ////////////////////////////////////////////////////////////////////////////
  // Special event trigger
  // RULE6: trigger pulse at match
  // RULE21: one-cycle gated pulses
  // RULE5: converter start gated
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sev_r <= 1'b0;
      adc_r <= 1'b0;
    end else begin
      sev_r <= match_hit & special_mode;
      adc_r <= match_hit & special_mode & adc_enable;
    end
  end

  // RULE6: clear waits timer edge
  // RULE12: tick from divided or external clock
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r <= 1'b0;
    end else if (match_hit && special_mode) begin
      pend_r <= 1'b1;
    end else if (timer_clk_rise || !special_mode) begin
      pend_r <= 1'b0;
    end
  end

  // RULE8: recheck before clearing
  // RULE7: clear without overflow
  // The timer treats this strobe as a load of zero, which never counts as overflow
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tclr_r <= 1'b0;
    end else begin
      tclr_r <= pend_r & timer_clk_rise & special_mode & equal_now;
    end
  end

  assign special_event = sev_r;
  assign adc_start = adc_r;
  assign timer_clear = tclr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sleep hold for the timer
  // RULE14: hold count in sleep
  // RULE11: timer mode set outside
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= sleep_active & ~timer_ext_clk;
    end
  end

  assign timer_hold = hold_r;

endmodule
`default_nettype wire

// >>> logic/tmcu_pkg.sv
// Package for the timer match compare unit: register map, fields, modes and decode functions
package tmcu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses, one aligned 32-bit word each
  localparam logic [3:0] TMCU_OFS_CONTROL = 4'h0;
  localparam logic [3:0] TMCU_OFS_VALUE_LOW = 4'h4;
  localparam logic [3:0] TMCU_OFS_VALUE_HIGH = 4'h8;
  localparam logic [3:0] TMCU_OFS_STATUS = 4'hc;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and widths
  localparam int TMCU_REG_W = 8;
  localparam int TMCU_CNT_W = 16;
  localparam logic [7:0] TMCU_CONTROL_RST = 8'h00;
  localparam logic [15:0] TMCU_VALUE_RST = 16'h0000;
  localparam logic [7:0] TMCU_CONTROL_OFF = 8'h00;

  // Status word bit positions
  localparam int TMCU_STAT_FLAG = 0;
  localparam int TMCU_STAT_PEND = 1;
  localparam int TMCU_STAT_PIN = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode field encodings
  localparam logic [3:0] TMCU_MODE_OFF = 4'h0;
  localparam logic [3:0] TMCU_MODE_TOGGLE = 4'h2;
  localparam logic [3:0] TMCU_MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] TMCU_MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] TMCU_MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] TMCU_MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] TMCU_MODE_SET = 4'h8;
  localparam logic [3:0] TMCU_MODE_CLEAR = 4'h9;
  localparam logic [3:0] TMCU_MODE_SWINT = 4'ha;
  localparam logic [3:0] TMCU_MODE_SPECIAL = 4'hb;

  // Capture prescaler selects and their terminal counts
  localparam logic [1:0] TMCU_PRE_FALL = 2'h0;
  localparam logic [1:0] TMCU_PRE_RISE = 2'h1;
  localparam logic [1:0] TMCU_PRE_RISE4 = 2'h2;
  localparam logic [1:0] TMCU_PRE_RISE16 = 2'h3;
  localparam logic [3:0] TMCU_PRE_LAST4 = 4'h3;
  localparam logic [3:0] TMCU_PRE_LAST16 = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Control register layout
  typedef struct packed {
    logic [1:0] bridge_output_mode_field;
    logic [1:0] duty_low_bits;
    logic [3:0] operating_mode_field;
  } tmcu_control_t;

  function automatic logic tmcu_is_capture(input logic [3:0] mode);
    tmcu_is_capture = (mode >= TMCU_MODE_CAP_FALL) && (mode <= TMCU_MODE_CAP_RISE16);
  endfunction

  function automatic logic tmcu_is_compare(input logic [3:0] mode);
    tmcu_is_compare = (mode == TMCU_MODE_TOGGLE) || ((mode >= TMCU_MODE_SET) && (mode <= TMCU_MODE_SPECIAL));
  endfunction

  function automatic logic tmcu_drives_pin(input logic [3:0] mode);
    tmcu_drives_pin = (mode == TMCU_MODE_TOGGLE) || (mode == TMCU_MODE_SET) || (mode == TMCU_MODE_CLEAR);
  endfunction

endpackage

// >>> logic/tmcu_capture_edge.sv
// Pin synchroniser, edge detector and capture prescaler for the compare unit
`timescale 1ns/1ps
`default_nettype none
module tmcu_capture_edge
  import tmcu_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic pin_async,
  input wire logic capture_on,
  input wire logic [1:0] prescale_sel,
  output logic pin_level,
  output logic capture_event
);

  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic [3:0] pre_cnt_r;
  logic [3:0] pre_last;
  logic rise;
  logic fall;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser; only the second stage is looked at
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      sync1_r <= pin_async;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  assign pin_level = sync2_r;
  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;
  assign pre_last = (prescale_sel == TMCU_PRE_RISE16) ? TMCU_PRE_LAST16 : TMCU_PRE_LAST4;

  ////////////////////////////////////////////////////////////////////////////
  // RULE18: prescaler cleared off
  // Only leaving capture, reset or a rise at the terminal count clears the count; a new select keeps it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt_r <= 4'h0;
    end else if (!capture_on) begin
      pre_cnt_r <= 4'h0;
    end else if (rise && prescale_sel[1]) begin
      if (pre_cnt_r >= pre_last) begin
        pre_cnt_r <= 4'h0;
      end else begin
        pre_cnt_r <= pre_cnt_r + 4'h1;
      end
    end
  end

  // RULE16: capture event select
  always_comb begin
    capture_event = 1'b0;
    if (capture_on) begin
      unique case (prescale_sel)
        TMCU_PRE_FALL: capture_event = fall;
        TMCU_PRE_RISE: capture_event = rise;
        TMCU_PRE_RISE4, TMCU_PRE_RISE16: capture_event = rise && (pre_cnt_r >= pre_last);
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> tb/tmcu_properties.sv
// Port-level checker for the timer match compare unit
`timescale 1ns/1ps
`default_nettype none
module tmcu_properties (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic timer_clk_rise,
  input wire logic timer_ext_clk,
  input wire logic adc_enable,
  input wire logic sleep_active,
  input wire logic module_pin_oe_n,
  input wire logic special_event,
  input wire logic timer_clear,
  input wire logic adc_start,
  input wire logic timer_hold,
  input wire logic module_interrupt_flag
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Trigger and timer clear are lone pulses
  sequence trig_s;
    special_event ##1 !special_event;
  endsequence
  sequence clr_s;
    timer_clear ##1 !timer_clear;
  endsequence
  trig_pulse_a: assert property (special_event |-> trig_s)
    else $error("trigger wider than one cycle");
  clear_pulse_a: assert property (timer_clear |-> clr_s)
    else $error("timer clear wider than one cycle");
  adc_gate_a: assert property (adc_start == (special_event && $past(adc_enable)))
    else $error("converter start not trigger gated by enable");
  flag_with_a: assert property (special_event |-> module_interrupt_flag)
    else $error("trigger without interrupt flag");
  // A rise in the match cycle itself must not launch the clear
  clear_wait_a: assert property (timer_clear |-> $past(timer_clk_rise) && !special_event)
    else $error("timer clear not after a later timer clock rise");
  pin_free_a: assert property (special_event |-> module_pin_oe_n)
    else $error("pin driven in trigger mode");
  sleep_block_a: assert property ($past(sleep_active) |-> !special_event)
    else $error("trigger while asleep");
  hold_on_a: assert property (sleep_active && !timer_ext_clk |=> timer_hold)
    else $error("timer not held in sleep");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered next cycle");
  bus_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
endmodule
`default_nettype wire

// >>> tb/tmcu_timer_model.sv
// Behavioural shared timer ticking on the instruction clock
`timescale 1ns/1ps
`default_nettype none
module tmcu_timer_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic timer_clear,
  input wire logic timer_hold,
  output logic [15:0] timer_count,
  output logic timer_clk_rise,
  output logic overflow_flag
);
  logic [1:0] div_r;
  ////////////////////////////////////////
  // synchronous tick at mclk over four, frozen when held
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= 2'h0;
      timer_clk_rise <= 1'b0;
    end else if (run && !timer_hold) begin
      div_r <= div_r + 2'h1;
      timer_clk_rise <= (div_r == 2'h3);
    end else begin
      timer_clk_rise <= 1'b0;
    end
  end
  // clear wins over a tick and leaves the overflow flag alone
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      timer_count <= 16'h0000;
      overflow_flag <= 1'b0;
    end else if (timer_clear) begin
      timer_count <= 16'h0000;
    end else if (timer_clk_rise) begin
      timer_count <= timer_count + 16'h0001;
      overflow_flag <= overflow_flag | (timer_count == 16'hffff);
    end
  end
endmodule
`default_nettype wire

// >>> tb/tmcu_tb_top.sv
// Self-checking bench for the timer match compare unit
`timescale 1ns/1ps
`default_nettype none
module tmcu_tb_top
  import tmcu_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic timer_ext_clk = 1'b0;
  logic adc_enable = 1'b0;
  logic sleep_active = 1'b0;
  logic module_pin_in = 1'b0;
  logic run = 1'b1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, timer_clk_rise, module_pin_out, module_pin_oe_n, special_event;
  logic timer_clear, adc_start, timer_hold, module_interrupt_flag, overflow_flag;
  logic [15:0] timer_count;
  logic [31:0] r;
  logic [15:0] tgt;
  int bad_count = 0;
  int checks_done = 0;
  wire [2:0] mon = {timer_clear, special_event, module_interrupt_flag};
  logic [3:0] cmp_mode [4] = '{TMCU_MODE_SET, TMCU_MODE_CLEAR, TMCU_MODE_TOGGLE, TMCU_MODE_SWINT};
  // Expected {drive enable low-active, latch}
  logic [1:0] cmp_exp [4] = '{2'h1, 2'h0, 2'h1, 2'h3};
  logic [3:0] cap_mode [4] = '{TMCU_MODE_CAP_FALL, TMCU_MODE_CAP_RISE, TMCU_MODE_CAP_RISE4, TMCU_MODE_CAP_RISE16};
  int cap_edges [4] = '{1, 1, 4, 16};

  always #5 mclk = ~mclk;

  tmcu_top DUT (.mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .timer_count, .timer_clk_rise, .timer_ext_clk, .adc_enable, .sleep_active,
    .module_pin_in, .module_pin_out, .module_pin_oe_n, .special_event, .timer_clear, .adc_start, .timer_hold,
    .module_interrupt_flag);
  tmcu_timer_model tmod (.mclk, .reset_n, .run, .timer_clear, .timer_hold, .timer_count, .timer_clk_rise,
    .overflow_flag);

  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] want, input logic [31:0] got);
    checks_done++;
    if (got !== want) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, want, got);
    end
  endtask

  task automatic hang(input string nm);
    bad_count++;
    $display("MISMATCH %s expected response seen timeout", nm);
    end_of_test();
  endtask

  // Request held until waitrequest is sampled low; entered just after an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] b = 4'h1);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= b;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge mclk);
      n++;
      if (n > 50) hang("waitrequest");
    end
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait_hi(input int k);
    int n;
    n = 0;
    while (mon[k] !== 1'b1) begin
      @(posedge mclk);
      n++;
      if (n > 3000) hang("event");
    end
  endtask

  // Match lands some thirty ticks ahead, clear of the three set-up writes
  task automatic arm(input logic [3:0] m);
    tgt = timer_count + 16'h001e;
    bus(1'b1, TMCU_OFS_VALUE_LOW, tgt[7:0]);
    bus(1'b1, TMCU_OFS_VALUE_HIGH, tgt[15:8]);
    bus(1'b1, TMCU_OFS_CONTROL, {4'h0, m});
  endtask

  task automatic pulse();
    module_pin_in <= 1'b1;
    repeat (4) @(posedge mclk);
    module_pin_in <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, 4'(a), 8'h00);
      chk("reset value", 32'h0, r);
    end
    bus(1'b1, 4'hd, 8'hff);
    bus(1'b0, 4'hd, 8'h00);
    chk("unmapped", 32'h0, r);
    bus(1'b1, TMCU_OFS_CONTROL, 8'hf0, 4'h0);
    bus(1'b0, TMCU_OFS_CONTROL, 8'h00);
    chk("masked write", 32'h0, r);
    bus(1'b1, TMCU_OFS_CONTROL, 8'hf0);
    bus(1'b0, TMCU_OFS_CONTROL, 8'h00);
    chk("control", 32'hf0, r);
    for (int i = 0; i < 4; i++) begin
      arm(cmp_mode[i]);
      wait_hi(0);
      chk("pin", {30'h0, cmp_exp[i]}, {30'h0, module_pin_oe_n, module_pin_out});
      bus(1'b1, TMCU_OFS_STATUS, 8'h01);
    end
    bus(1'b1, TMCU_OFS_CONTROL, 8'h00);
    chk("latch after off", 32'h0, {31'h0, module_pin_out});
    adc_enable <= 1'b1;
    arm(TMCU_MODE_SPECIAL);
    wait_hi(1);
    chk("converter start", 32'h1, {31'h0, adc_start});
    wait_hi(2);
    @(posedge mclk);
    chk("timer cleared", 32'h0, {16'h0, timer_count});
    chk("overflow flag", 32'h0, {31'h0, overflow_flag});
    adc_enable <= 1'b0;
    bus(1'b1, TMCU_OFS_STATUS, 8'h01);
    arm(TMCU_MODE_SPECIAL);
    wait_hi(1);
    run <= 1'b0;
    chk("gated start", 32'h0, {31'h0, adc_start});
    // Moved below the count, so the next tick cannot make a fresh match
    bus(1'b1, TMCU_OFS_VALUE_LOW, tgt[7:0] - 8'h01);
    run <= 1'b1;
    repeat (12) @(posedge mclk);
    bus(1'b0, TMCU_OFS_STATUS, 8'h00);
    chk("clear pending", 32'h0, {31'h0, r[TMCU_STAT_PEND]});
    chk("timer kept", 32'h1, {31'h0, timer_count > tgt});
    run <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      bus(1'b1, TMCU_OFS_CONTROL, 8'h00);
      bus(1'b1, TMCU_OFS_STATUS, 8'h01);
      bus(1'b1, TMCU_OFS_CONTROL, {4'h0, cap_mode[j]});
      repeat (cap_edges[j] - 1) pulse();
      chk("early capture", 32'h0, {31'h0, module_interrupt_flag});
      pulse();
      chk("capture flag", 32'h1, {31'h0, module_interrupt_flag});
    end
    bus(1'b0, TMCU_OFS_VALUE_LOW, 8'h00);
    chk("captured low", {24'h0, timer_count[7:0]}, r);
    bus(1'b0, TMCU_OFS_VALUE_HIGH, 8'h00);
    chk("captured high", {24'h0, timer_count[15:8]}, r);
    bus(1'b1, TMCU_OFS_CONTROL, 8'h00);
    bus(1'b1, TMCU_OFS_STATUS, 8'h01);
    bus(1'b1, TMCU_OFS_CONTROL, {4'h0, TMCU_MODE_CAP_RISE});
    timer_ext_clk <= 1'b1;
    sleep_active <= 1'b1;
    run <= 1'b1;
    pulse();
    chk("sleep capture", 32'h1, {31'h0, module_interrupt_flag});
    chk("no hold", 32'h0, {31'h0, timer_hold});
    timer_ext_clk <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("hold", 32'h1, {31'h0, timer_hold});
    @(posedge mclk);
    tgt = timer_count;
    repeat (8) @(posedge mclk);
    chk("count held", {16'h0, tgt}, {16'h0, timer_count});
    sleep_active <= 1'b0;
    end_of_test();
  end
endmodule

bind tmcu_top tmcu_properties props (.mclk, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .timer_clk_rise,
  .timer_ext_clk, .adc_enable, .sleep_active, .module_pin_oe_n, .special_event, .timer_clear, .adc_start,
  .timer_hold, .module_interrupt_flag);
`default_nettype wire
